// File: logic/lmks_pkg.sv
// shared constants and types of the led matrix and key scan driver
package lmks_pkg;
   // matrix geometry
   localparam int NUM_ROW = 16;
   localparam int NUM_COM = 8;
   localparam int NUM_KEY = 13;
   localparam int NUM_KS = 3;
   localparam int NUM_ASEL = 3;
   localparam int RAM_DEPTH = 16;
   localparam int KEY_ROW_LO = 3;
   localparam int INT_ROW = 15;
   localparam int NUM_SLOT = NUM_COM + NUM_KS;
   localparam int NUM_PHASE = 16;
   localparam int KEY_BYTES = 6;
   // timing, oscillator at 20 MHz
   localparam int CLK_MHZ = 20;
   localparam int DIM_STEP_NS = 400;
   localparam int POR_SENSE_NS = 1000;
   localparam int DIM_STEP_CYC = (DIM_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int POR_SENSE_CYC = (POR_SENSE_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_W = $clog2(DIM_STEP_CYC);
   localparam int POR_W = $clog2(POR_SENSE_CYC);
   // bus address: upper bits fixed at DEV_BASE, lower bits strapped
   localparam logic [3:0] DEV_BASE = 4'h7;
   // command byte: upper nibble selects, lower nibble carries the value
   localparam logic [3:0] CMD_PTR = 4'h0;
   localparam logic [3:0] CMD_SETUP = 4'h2;
   localparam logic [3:0] CMD_KEYPTR = 4'h4;
   localparam logic [3:0] CMD_DIM = 4'hE;
   localparam int SETUP_ROWINT_BIT = 0;
   localparam int SETUP_POL_BIT = 1;
   // reset values
   localparam logic [3:0] DIM_RST = 4'hF;
   localparam logic ROWINT_RST = 1'h0;
   localparam logic POL_RST = 1'h0;
   // packet kinds crossing from the link to the oscillator domain
   localparam logic [1:0] PK_RAM = 2'h0;
   localparam logic [1:0] PK_SETUP = 2'h1;
   localparam logic [1:0] PK_DIM = 2'h2;
   typedef struct packed {
      logic [1:0] kind;
      logic [3:0] addr;
      logic [7:0] data;
   } lmks_pkt_s;
   typedef enum logic {SC_POR, SC_RUN} lmks_scan_e;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} lmks_bus_e;
endpackage

// File: logic/lmks_top.sv
// led matrix driver with key scan and serial bus slave
// Behaviour
// - display held in sixteen by eight RAM
// - drive sixteen segments and eight commons
// - RAM address advances after each byte
// - scan thirteen by three keys, store states
// - selected common low, others high
// - common zero high at reset and scanning
// - commons one to three source keys
// - segment high lights LED in selected common
// - first three rows sense address, pulled down
// - other rows sense keys during scan
// - select zero: last row segment and key
// - select one: last row is interrupt
// - polarity bit sets interrupt active level
// - serial bus slave, clock in, data open-drain
`timescale 1ns/10ps
module lmks_top
(
   // oscillator domain
   input wire logic i_clk,
   input wire logic i_rstn,
   // serial bus, sampled on the link clock
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   // matrix pins
   output logic [lmks_pkg::NUM_COM-1:0] o_common_line,
   input wire logic [lmks_pkg::NUM_ROW-1:0] i_row,
   output logic [lmks_pkg::NUM_ROW-1:0] o_row,
   output logic [lmks_pkg::NUM_ROW-1:0] o_row_oe_n,
   output logic o_row_pulldown
);
   localparam int NK = lmks_pkg::NUM_KEY;

   // ---------------- oscillator domain ----------------
   lmks_pkg::lmks_scan_e scan_ff;
   logic [lmks_pkg::POR_W-1:0] por_cnt_ff;
   logic [lmks_pkg::STEP_W-1:0] step_ff;
   logic [3:0] phase_ff;
   logic [3:0] slot_ff;
   logic [lmks_pkg::NUM_ROW-1:0] row_s1_ff, row_s2_ff;
   logic [lmks_pkg::NUM_ASEL-1:0] asel_ff;
   logic [7:0] disp_ff [lmks_pkg::RAM_DEPTH];
   logic [NK-1:0] key_cur_ff [lmks_pkg::NUM_KS];
   logic [NK*lmks_pkg::NUM_KS-1:0] key_snap_ff;
   logic ktgl_ff;
   logic [2:0] ptgl_s_ff;
   logic rowint_ff, pol_ff;
   logic [3:0] dim_ff;
   logic [lmks_pkg::NUM_COM-1:0] nxt_com;
   logic [lmks_pkg::NUM_ROW-1:0] nxt_row, nxt_oe_n, disp_row;
   logic nxt_pd, in_key, slot_end, key_any, int_lvl, pkt_new;
   logic [1:0] ks;
   logic [NK-1:0] key_in;
   // link side, declared here because both domains name them
   lmks_pkg::lmks_pkt_s pkt_ff;
   logic ptgl_ff;

   assign in_key = (slot_ff >= 4'(lmks_pkg::NUM_COM));
   assign ks = 2'(slot_ff - 4'(lmks_pkg::NUM_COM));
   assign slot_end = (step_ff == lmks_pkg::STEP_W'(lmks_pkg::DIM_STEP_CYC - 1))
      && (phase_ff == 4'(lmks_pkg::NUM_PHASE - 1));
   assign disp_row = {disp_ff[{slot_ff[2:0], 1'b1}], disp_ff[{slot_ff[2:0], 1'b0}]};
   assign key_any = |key_snap_ff;
   assign int_lvl = pol_ff ? key_any : ~key_any;
   // only the second stage and its follower are compared
   assign pkt_new = ptgl_s_ff[1] ^ ptgl_s_ff[2];
   // the interrupt pin cannot also sense, so its key bit is masked
   assign key_in = row_s2_ff[lmks_pkg::NUM_ROW-1:lmks_pkg::KEY_ROW_LO]
      & ~(NK'(rowint_ff) << (NK - 1));

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         row_s1_ff <= '0;
         row_s2_ff <= '0;
         ptgl_s_ff <= '0;
      end
      else
      begin
         row_s1_ff <= i_row;
         row_s2_ff <= row_s1_ff;
         ptgl_s_ff <= {ptgl_s_ff[1:0], ptgl_ff};
      end
   end

   // display copy and settings arrive as packets from the link domain
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         for (int i = 0; i < lmks_pkg::RAM_DEPTH; i++)
            disp_ff[i] <= '0;
         rowint_ff <= lmks_pkg::ROWINT_RST;
         pol_ff <= lmks_pkg::POL_RST;
         dim_ff <= lmks_pkg::DIM_RST;
      end
      else if (pkt_new)
      begin
         unique case (pkt_ff.kind)
            lmks_pkg::PK_RAM: disp_ff[pkt_ff.addr] <= pkt_ff.data;
            lmks_pkg::PK_SETUP:
            begin
               rowint_ff <= pkt_ff.data[lmks_pkg::SETUP_ROWINT_BIT];
               pol_ff <= pkt_ff.data[lmks_pkg::SETUP_POL_BIT];
            end
            lmks_pkg::PK_DIM: dim_ff <= pkt_ff.data[3:0];
            default: dim_ff <= dim_ff;
         endcase
      end
   end

   // power-on address sense, then a frame of display slots and key slots
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         scan_ff <= lmks_pkg::SC_POR;
         por_cnt_ff <= '0;
         asel_ff <= '0;
         step_ff <= '0;
         phase_ff <= '0;
         slot_ff <= '0;
      end
      else if (scan_ff == lmks_pkg::SC_POR)
      begin
         por_cnt_ff <= por_cnt_ff + 1'b1;
         if (por_cnt_ff == lmks_pkg::POR_W'(lmks_pkg::POR_SENSE_CYC - 1))
         begin
            asel_ff <= {row_s2_ff[0], row_s2_ff[1], row_s2_ff[2]};
            scan_ff <= lmks_pkg::SC_RUN;
         end
      end
      else
      begin
         step_ff <= (step_ff == lmks_pkg::STEP_W'(lmks_pkg::DIM_STEP_CYC - 1)) ? '0
            : step_ff + 1'b1;
         if (step_ff == lmks_pkg::STEP_W'(lmks_pkg::DIM_STEP_CYC - 1))
            phase_ff <= phase_ff + 1'b1;
         if (slot_end)
            slot_ff <= (slot_ff == 4'(lmks_pkg::NUM_SLOT - 1)) ? '0 : slot_ff + 1'b1;
      end
   end

   // key states caught at the end of each key slot, published per frame
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         for (int i = 0; i < lmks_pkg::NUM_KS; i++)
            key_cur_ff[i] <= '0;
         key_snap_ff <= '0;
         ktgl_ff <= 1'b0;
      end
      else if (scan_ff == lmks_pkg::SC_RUN)
      begin
         if (in_key && slot_end)
            key_cur_ff[ks] <= key_in;
         if (slot_ff == '0 && phase_ff == '0 && step_ff == '0)
         begin
            key_snap_ff <= {key_cur_ff[2], key_cur_ff[1], key_cur_ff[0]};
            ktgl_ff <= ~ktgl_ff;
         end
      end
   end

   always_comb
   begin
      nxt_com = '1;
      nxt_row = '0;
      nxt_oe_n = '1;
      nxt_pd = 1'b0;
      if (scan_ff == lmks_pkg::SC_POR)
      begin
         nxt_com = '0;
         nxt_com[0] = 1'b1;
         nxt_pd = 1'b1;
      end
      else if (in_key)
      begin
         nxt_com = '0;
         nxt_com[0] = 1'b1;
         nxt_com[ks + 2'h1] = 1'b1;
         nxt_pd = 1'b1;
      end
      else
      begin
         nxt_com[slot_ff[2:0]] = 1'b0;
         nxt_oe_n = '0;
         if (phase_ff <= dim_ff)
            nxt_row = disp_row;
      end
      if (rowint_ff)
      begin
         nxt_oe_n[lmks_pkg::INT_ROW] = 1'b0;
         nxt_row[lmks_pkg::INT_ROW] = int_lvl;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_common_line <= '1;
         o_row <= '0;
         o_row_oe_n <= '1;
         o_row_pulldown <= 1'b0;
      end
      else
      begin
         o_common_line <= nxt_com;
         o_row <= nxt_row;
         o_row_oe_n <= nxt_oe_n;
         o_row_pulldown <= nxt_pd;
      end
   end

   // ---------------- link domain ----------------
   lmks_pkg::lmks_bus_e st_ff;
   logic [1:0] lrst_ff;
   logic [2:0] scl_s_ff, sda_s_ff, ktgl_s_ff;
   logic [lmks_pkg::NUM_ASEL-1:0] asel_s1_ff, asel_s2_ff;
   logic [NK*lmks_pkg::NUM_KS-1:0] key_l_ff;
   logic [7:0] ram_ff [lmks_pkg::RAM_DEPTH];
   logic [7:0] sh_ff, byte_in, tx_byte;
   logic [2:0] bit_ff;
   logic [4:0] ptr_ff;
   logic first_ff, rw_ff, sda_low_ff, ack_ff;
   logic scl_rise, scl_fall, bus_start, bus_stop, lrstn;

   function automatic logic [4:0] lmks_inc(input logic [4:0] p);
      lmks_inc = {p[4], p[3:0] + 4'h1};
   endfunction

   assign lrstn = lrst_ff[1];
   assign scl_rise = scl_s_ff[1] & ~scl_s_ff[2];
   assign scl_fall = ~scl_s_ff[1] & scl_s_ff[2];
   assign bus_start = scl_s_ff[1] & scl_s_ff[2] & ~sda_s_ff[1] & sda_s_ff[2];
   assign bus_stop = scl_s_ff[1] & scl_s_ff[2] & sda_s_ff[1] & ~sda_s_ff[2];
   assign byte_in = {sh_ff[6:0], sda_s_ff[1]};
   assign tx_byte = !ptr_ff[4] ? ram_ff[ptr_ff[3:0]]
      : (ptr_ff[2:0] >= 3'(lmks_pkg::KEY_BYTES)) ? 8'h00
      : 8'(16'(key_l_ff[NK*ptr_ff[2:1] +: NK]) >> (8 * ptr_ff[0]));
   assign o_sda = 1'b0;
   assign o_sda_oe_n = ~sda_low_ff;

   always_ff @(posedge i_link_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         lrst_ff <= '0;
      else
         lrst_ff <= {lrst_ff[0], 1'b1};
   end

   always_ff @(posedge i_link_clk or negedge lrstn)
   begin
      if (!lrstn)
      begin
         scl_s_ff <= '1;
         sda_s_ff <= '1;
         ktgl_s_ff <= '0;
         asel_s1_ff <= '0;
         asel_s2_ff <= '0;
         key_l_ff <= '0;
      end
      else
      begin
         scl_s_ff <= {scl_s_ff[1:0], i_scl};
         sda_s_ff <= {sda_s_ff[1:0], i_sda};
         ktgl_s_ff <= {ktgl_s_ff[1:0], ktgl_ff};
         asel_s1_ff <= asel_ff;
         asel_s2_ff <= asel_s1_ff;
         // the snapshot holds still for a whole frame after its toggle
         if (ktgl_s_ff[1] ^ ktgl_s_ff[2])
            key_l_ff <= key_snap_ff;
      end
   end

   // serial slave; settings leave only as toggled packets
   always_ff @(posedge i_link_clk or negedge lrstn)
   begin
      if (!lrstn)
      begin
         st_ff <= lmks_pkg::I_IDLE;
         bit_ff <= '0;
         sh_ff <= '0;
         ptr_ff <= '0;
         first_ff <= 1'b0;
         rw_ff <= 1'b0;
         ack_ff <= 1'b0;
         sda_low_ff <= 1'b0;
         pkt_ff <= '0;
         ptgl_ff <= 1'b0;
         for (int i = 0; i < lmks_pkg::RAM_DEPTH; i++)
            ram_ff[i] <= '0;
      end
      else if (bus_start)
      begin
         st_ff <= lmks_pkg::I_ADDR;
         bit_ff <= '0;
         first_ff <= 1'b1;
         sda_low_ff <= 1'b0;
      end
      else if (bus_stop)
      begin
         st_ff <= lmks_pkg::I_IDLE;
         sda_low_ff <= 1'b0;
      end
      else
      begin
         unique case (st_ff)
            lmks_pkg::I_IDLE: st_ff <= lmks_pkg::I_IDLE;
            lmks_pkg::I_ADDR, lmks_pkg::I_WR:
               if (scl_rise)
               begin
                  sh_ff <= byte_in;
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7 && st_ff == lmks_pkg::I_ADDR)
                  begin
                     rw_ff <= byte_in[0];
                     st_ff <= (byte_in[7:1] == {lmks_pkg::DEV_BASE, asel_s2_ff})
                        ? lmks_pkg::I_AACK : lmks_pkg::I_IDLE;
                  end
                  else if (bit_ff == 3'h7)
                  begin
                     st_ff <= lmks_pkg::I_WACK;
                     first_ff <= 1'b0;
                     if (!first_ff)
                     begin
                        if (!ptr_ff[4])
                        begin
                           ram_ff[ptr_ff[3:0]] <= byte_in;
                           pkt_ff <= '{lmks_pkg::PK_RAM, ptr_ff[3:0], byte_in};
                           ptgl_ff <= ~ptgl_ff;
                        end
                        ptr_ff <= lmks_inc(ptr_ff);
                     end
                     else if (byte_in[7:4] == lmks_pkg::CMD_PTR)
                        ptr_ff <= {1'b0, byte_in[3:0]};
                     else if (byte_in[7:4] == lmks_pkg::CMD_KEYPTR)
                        ptr_ff <= {1'b1, byte_in[3:0]};
                     else if (byte_in[7:4] == lmks_pkg::CMD_SETUP
                        || byte_in[7:4] == lmks_pkg::CMD_DIM)
                     begin
                        pkt_ff <= '{(byte_in[7:4] == lmks_pkg::CMD_DIM) ? lmks_pkg::PK_DIM
                           : lmks_pkg::PK_SETUP, 4'h0, byte_in};
                        ptgl_ff <= ~ptgl_ff;
                     end
                  end
               end
            lmks_pkg::I_AACK, lmks_pkg::I_WACK:
               if (scl_fall && !ack_ff)
               begin
                  sda_low_ff <= 1'b1;
                  ack_ff <= 1'b1;
               end
               else if (scl_fall)
               begin
                  ack_ff <= 1'b0;
                  bit_ff <= '0;
                  if (st_ff == lmks_pkg::I_AACK && rw_ff)
                  begin
                     st_ff <= lmks_pkg::I_RD;
                     sh_ff <= tx_byte;
                     sda_low_ff <= ~tx_byte[7];
                     ptr_ff <= lmks_inc(ptr_ff);
                  end
                  else
                  begin
                     st_ff <= lmks_pkg::I_WR;
                     sda_low_ff <= 1'b0;
                  end
               end
            lmks_pkg::I_RD:
               if (scl_fall && bit_ff == 3'h7)
               begin
                  st_ff <= lmks_pkg::I_RACK;
                  sda_low_ff <= 1'b0;
               end
               else if (scl_fall)
               begin
                  bit_ff <= bit_ff + 3'h1;
                  sh_ff <= {sh_ff[6:0], 1'b0};
                  sda_low_ff <= ~sh_ff[6];
               end
            lmks_pkg::I_RACK:
               if (scl_rise && sda_s_ff[1])
                  st_ff <= lmks_pkg::I_IDLE;
               else if (scl_fall)
               begin
                  st_ff <= lmks_pkg::I_RD;
                  bit_ff <= '0;
                  sh_ff <= tx_byte;
                  sda_low_ff <= ~tx_byte[7];
                  ptr_ff <= lmks_inc(ptr_ff);
               end
            default: st_ff <= lmks_pkg::I_IDLE;
         endcase
      end
   end

   // ---------------- checks ----------------
   property p_ptr_inc;
      @(posedge i_link_clk) disable iff (!lrstn)
      (st_ff == lmks_pkg::I_WR && scl_rise && bit_ff == 3'h7 && !first_ff && !bus_start
         && !bus_stop) |=> ptr_ff == {$past(ptr_ff[4]), $past(ptr_ff[3:0]) + 4'h1};
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");
   property p_sda_idle;
      @(posedge i_link_clk) disable iff (!lrstn)
      (st_ff == lmks_pkg::I_IDLE) |-> o_sda_oe_n;
   endproperty
   a_sda_idle: assert property (p_sda_idle) else $error("data driven while idle");
   property p_com_sel;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_RUN && !in_key) |=> ($countones(~o_common_line) == 1)
         && !o_common_line[$past(slot_ff[2:0])];
   endproperty
   a_com_sel: assert property (p_com_sel) else $error("wrong common selected");
   property p_src0;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_POR || in_key) |=> o_common_line[0];
   endproperty
   a_src0: assert property (p_src0) else $error("common zero not high");
   property p_ksrc;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_RUN && in_key) |=> o_common_line[$past(ks) + 2'h1]
         && $countones(o_common_line) == 2;
   endproperty
   a_ksrc: assert property (p_ksrc) else $error("key source wrong");
   property p_key_pins;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_RUN && in_key) |=> o_row_pulldown
         && (&o_row_oe_n[lmks_pkg::INT_ROW-1:0]);
   endproperty
   a_key_pins: assert property (p_key_pins) else $error("rows driven in key slot");
   property p_addr_sense;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_POR) |=> o_row_pulldown && (&o_row_oe_n[2:0]);
   endproperty
   a_addr_sense: assert property (p_addr_sense) else $error("address pins driven");
   property p_dim;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_RUN && !in_key && phase_ff > dim_ff)
         |=> o_row[lmks_pkg::INT_ROW-1:0] == '0;
   endproperty
   a_dim: assert property (p_dim) else $error("segment lit past dim level");
   property p_seg;
      @(posedge i_clk) disable iff (!i_rstn)
      (scan_ff == lmks_pkg::SC_RUN && !in_key && phase_ff <= dim_ff && !rowint_ff)
         |=> o_row == $past(disp_row) && o_row_oe_n == '0;
   endproperty
   a_seg: assert property (p_seg) else $error("segments differ from RAM");
   property p_int;
      @(posedge i_clk) disable iff (!i_rstn)
      rowint_ff |=> !o_row_oe_n[lmks_pkg::INT_ROW]
         && o_row[lmks_pkg::INT_ROW] == ($past(pol_ff) ~^ $past(key_any));
   endproperty
   a_int: assert property (p_int) else $error("interrupt pin level wrong");
endmodule

// File: verification/lmks_host.sv
// two-wire bus master model standing in for the host controller
`timescale 1ns/10ps
module lmks_host
(
   // bus pins, data open drain towards the wire, scl driven high and low
   output logic o_scl,
   output logic o_sda_oe_n,
   input wire logic i_sda
);
   // half period of scl in ns, raised by the bench to act as a slow host
   int half = 500;
   initial
   begin
      o_scl = 1'b1;
      o_sda_oe_n = 1'b1;
   end
   // data moves 100 ns after scl falls, so no bit is ever seen as a start or stop
   task automatic bit_x(input logic b, output logic r);
      o_sda_oe_n = b;
      #(half);
      o_scl = 1'b1;
      #(half);
      r = i_sda;
      o_scl = 1'b0;
      #100;
   endtask
   task automatic start();
      o_sda_oe_n = 1'b1;
      #(half);
      o_scl = 1'b1;
      #(half);
      o_sda_oe_n = 1'b0;
      #(half);
      o_scl = 1'b0;
      #100;
   endtask
   // scl is left high afterwards: the clock stands still between frames
   task automatic stop();
      o_sda_oe_n = 1'b0;
      #(half);
      o_scl = 1'b1;
      #(half);
      o_sda_oe_n = 1'b1;
      #(half);
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   task automatic get(output logic [7:0] d, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(last, r);
   endtask
endmodule

// File: verification/test_lmks_top.sv
// self-checking bench for the led matrix and key scan driver
`timescale 1ns/10ps
module test_lmks_top;
   logic i_clk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic tgl = 1'b0;
   logic scl, host_oe_n, sda, o_sda, o_sda_oe_n, o_row_pulldown, ack, pol, mon_on;
   logic [7:0] o_common_line;
   logic [15:0] i_row, o_row, o_row_oe_n;
   logic [2:0] strap;
   logic [3:0] dims [3];
   logic [12:0] keys [3];
   logic [7:0] ram [16];
   logic [7:0] got [$];
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int lit_cnt = 0;
   always #25 i_clk = ~i_clk;
   initial
   begin
      #7;
      forever #24 i_link_clk = ~i_link_clk;
   end
   always @(posedge i_clk)
      tgl <= ~tgl;
   // wired-and with the bus pull-up
   assign sda = (o_sda_oe_n | o_sda) & host_oe_n;
   lmks_top uut
   (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk), .i_scl(scl), .i_sda(sda),
      .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_common_line(o_common_line),
      .i_row(i_row), .o_row(o_row), .o_row_oe_n(o_row_oe_n), .o_row_pulldown(o_row_pulldown)
   );
   lmks_host host (.o_scl(scl), .o_sda_oe_n(host_oe_n), .i_sda(sda));
   function automatic logic key_hit(input int k);
      logic h = 1'b0;
      for (int s = 0; s < 3; s++)
         if (o_common_line == (8'h01 | (8'h02 << s)) && keys[s][k])
            h = 1'b1;
      return h;
   endfunction
   // a released row with no pull-down floats: give it a level that keeps changing
   always_comb
   begin
      for (int j = 0; j < 16; j++)
         if (!o_row_oe_n[j])
            i_row[j] = o_row[j];
         else if (!o_row_pulldown)
            i_row[j] = tgl;
         else if (j < 3)
            i_row[j] = strap[2-j];
         else
            i_row[j] = key_hit(j - 3);
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] cmd, input int n);
      host.start();
      host.put({lmks_pkg::DEV_BASE, strap, 1'b0}, ack);
      chk(16'(ack), 16'h1);
      host.put(cmd, ack);
      chk(16'(ack), 16'h1);
      for (int i = 0; i < n; i++)
      begin
         host.put(ram[(cmd[3:0] + i) % 16], ack);
         chk(16'(ack), 16'h1);
      end
      host.stop();
   endtask
   task automatic rd(input logic [7:0] cmd, input int n);
      logic [7:0] d;
      got = {};
      host.start();
      host.put({lmks_pkg::DEV_BASE, strap, 1'b0}, ack);
      host.put(cmd, ack);
      host.start();
      host.put({lmks_pkg::DEV_BASE, strap, 1'b1}, ack);
      chk(16'(ack), 16'h1);
      for (int i = 0; i < n; i++)
      begin
         host.get(d, i == n - 1);
         got.push_back(d);
      end
      host.stop();
   endtask
   // display slots are checked only while the ram model is settled
   always @(negedge i_clk)
      if (i_rstn && cyc > 40)
      begin
         if (o_common_line[0] && $countones(o_common_line) == 2)
            chk({o_row_pulldown, o_row_oe_n[14:0]}, 16'hFFFF);
         if (mon_on && $countones(o_common_line) == 7)
            for (int c = 0; c < 8; c++)
               if (!o_common_line[c] && o_row != 16'h0)
               begin
                  lit_cnt++;
                  chk(o_row, {ram[2*c+1], ram[2*c]});
                  chk({o_row_pulldown, o_row_oe_n[14:0]}, 16'h0);
               end
      end
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial
   begin
      void'($urandom(29444));
      strap = 3'($urandom);
      dims = '{4'hF, 4'h0, 4'($urandom)};
      foreach (keys[s])
         keys[s] = 13'h0;
      mon_on = 1'b0;
      waitc(8);
      #2 i_rstn = 1'b1;
      waitc(5);
      #2 chk({8'h0, o_common_line}, 16'h0001);
      chk({o_row_pulldown, o_row_oe_n[14:0]}, 16'hFFFF);
      waitc(60);
      host.start();
      host.put({lmks_pkg::DEV_BASE, ~strap, 1'b0}, ack);
      chk(16'(ack), 16'h0);
      host.stop();
      foreach (ram[i])
         ram[i] = 8'($urandom) | 8'h01;
      wr({lmks_pkg::CMD_PTR, 4'hA}, 16);
      host.half = 900;
      rd({lmks_pkg::CMD_PTR, 4'h0}, 17);
      host.half = 500;
      foreach (got[i])
         chk({8'h0, got[i]}, {8'h0, ram[i % 16]});
      foreach (dims[i])
      begin
         wr({lmks_pkg::CMD_DIM, dims[i]}, 0);
         waitc(1408);
         lit_cnt = 0;
         mon_on = 1'b1;
         waitc(2816);
         mon_on = 1'b0;
         chk(16'(lit_cnt), 16'(128 * (dims[i] + 1)));
      end
      foreach (keys[s])
         keys[s] = 13'($urandom);
      waitc(4224);
      rd({lmks_pkg::CMD_KEYPTR, 4'h0}, 6);
      foreach (got[i])
         chk({8'h0, got[i]}, {8'h0, 8'(keys[i / 2] >> (8 * (i % 2)))});
      keys[1] = 13'h0;
      keys[2] = 13'h0;
      for (int m = 0; m < 4; m++)
      begin
         pol = m[1];
         keys[0] = m[0] ? 13'h0001 : 13'h0000;
         wr({lmks_pkg::CMD_SETUP, 2'b00, pol, 1'b1}, 0);
         waitc(4224);
         // step off the launching edge before looking at the pin
         #2 chk({o_row_oe_n[15], o_row[15]}, {1'b0, pol ~^ m[0]});
      end
      wr({lmks_pkg::CMD_SETUP, 4'h0}, 0);
      waitc(1408);
      mon_on = 1'b1;
      waitc(1408);
      mon_on = 1'b0;
      tally_and_finish();
   end
endmodule
